// ==== verilog/cpu_irq_reset_bus_control.v ====
// Control and sequencing of the processor: width status, non-maskable edge capture,
// ready/wait handling, reset conditioning, interrupt/reset vector sequence and bus qualifiers.
// Assumes one clock; control pins are asynchronous and synchronised here, dataIn and instrDone are used directly; APB slave for control.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "cpu_ctl_defines.vh"
module cpu_irq_reset_bus_control
(
    input wire clk,
    input wire rst_n,
    input wire reset_in_n,
    input wire nonmaskable_irq_n,
    input wire maskable_irq_n,
    input wire abort_in_n,
    input wire bus_drive_enable,
    input wire readyIn,
    input wire instrDone,
    input wire [7:0] dataIn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg readyOut,
    output reg readyOe,
    output reg width_flags_status,
    output reg emulationOut,
    output reg read_not_write,
    output reg rwOe,
    output reg data_cycle_valid,
    output reg program_cycle_valid,
    output reg vector_fetch_n,
    output reg [23:0] addrOut,
    output reg [7:0] dataOut
);
    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer states.
    localparam [2:0] ST_RUN = 3'h0;
    localparam [2:0] ST_SEQ = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_STOP = 3'h3;
    localparam [2:0] ST_RESET = 3'h4;

    reg [2:0] state_q;
    reg [3:0] cyc_q;
    reg seqIsReset_q;
    reg [1:0] seqKind_q;
    reg [7:0] status_q;
    reg [7:0] programBank_q;
    reg [7:0] dataBank_q;
    reg [15:0] direct_q;
    reg [7:0] stackHi_q;
    reg [7:0] indexXHi_q;
    reg [7:0] indexYHi_q;
    reg [15:0] stack_q;
    reg [15:0] pc_q;
    reg [23:0] vecAddr_q;
    reg [15:0] absOperand_q;
    reg [7:0] ctrl_q;
    reg clkHalf_q;
    wire resetSync;
    wire irqSync;
    wire abortSync;
    wire beSync;
    wire readySync;
    wire nmiPending;
    wire nmiAccept;
    wire resetRelease;
    reg resetSeen_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    level_sync #(.RESET_VALUE(1'b0)) uRes (.clk(clk), .rst_n(rst_n), .pinIn(reset_in_n),
        .level_q(resetSync));
    level_sync #(.RESET_VALUE(1'b1)) uIrq (.clk(clk), .rst_n(rst_n), .pinIn(maskable_irq_n),
        .level_q(irqSync));
    level_sync #(.RESET_VALUE(1'b1)) uAbt (.clk(clk), .rst_n(rst_n), .pinIn(abort_in_n),
        .level_q(abortSync));
    level_sync #(.RESET_VALUE(1'b1)) uBe (.clk(clk), .rst_n(rst_n), .pinIn(bus_drive_enable),
        .level_q(beSync));
    level_sync #(.RESET_VALUE(1'b1)) uRdy (.clk(clk), .rst_n(rst_n), .pinIn(readyIn),
        .level_q(readySync));
    edge_pending uNmi (.clk(clk), .rst_n(rst_n), .pinN(nonmaskable_irq_n), .accept(nmiAccept),
        .pending_q(nmiPending));

    assign resetRelease = resetSync && !resetSeen_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Vector selection; the emulation flag picks the table half.
    function [23:0] vecSel;
        input [1:0] kind;
        input emu;
        begin
            case (kind)
                2'h0: vecSel = `VEC_RESET;
                2'h1: vecSel = emu ? `VEC_NMI_EMU : `VEC_NMI_NAT; // RULE3
                2'h2: vecSel = emu ? `VEC_ABT_EMU : `VEC_ABT_NAT;
                default: vecSel = emu ? `VEC_IRQ_EMU : `VEC_IRQ_NAT;
            endcase
        end
    endfunction

    function [23:0] bankZero;
        input [15:0] off;
        begin
            bankZero = {8'h00, off}; // RULE20
        end
    endfunction

    wire emu = ctrl_q[`CTRL_EMU];
    wire irqAsserted = !irqSync;
    wire irqTake = irqAsserted && !status_q[`P_IRQDIS];
    wire wakeAny = nmiPending || !abortSync || irqAsserted;
    // Ready from outside is only honoured when not in reset.
    wire halted = !readySync && readyOe == 1'b0 && state_q != ST_RESET; // RULE8 RULE12
    wire [23:0] vecNow = vecSel(seqKind_q, emu);
    assign nmiAccept = resetSync && !halted && nmiPending && (state_q == ST_WAIT ||
        (state_q == ST_RUN && instrDone && !ctrl_q[`CTRL_STOP] && !ctrl_q[`CTRL_WAIT]));

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer. A stopped clock simply freezes every flip-flop here. // RULE6
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_RESET;
            cyc_q <= 4'h0;
            seqIsReset_q <= 1'b1;
            seqKind_q <= 2'h0;
            status_q <= `RST_STATUS;
            programBank_q <= `RST_BANK;
            dataBank_q <= `RST_BANK;
            direct_q <= `RST_DIRECT;
            stackHi_q <= `RST_STACK_HI;
            indexXHi_q <= `RST_BANK;
            indexYHi_q <= `RST_BANK;
            stack_q <= 16'h01FF;
            pc_q <= 16'h0000;
            vecAddr_q <= `VEC_RESET;
            resetSeen_q <= 1'b0;
        end
        else if (!resetSync)
        begin
            state_q <= ST_RESET; // RULE13 RULE14
            cyc_q <= 4'h0;
            seqIsReset_q <= 1'b1;
            seqKind_q <= 2'h0;
            status_q <= `RST_STATUS;
            programBank_q <= `RST_BANK;
            dataBank_q <= `RST_BANK;
            direct_q <= `RST_DIRECT;
            stackHi_q <= `RST_STACK_HI;
            indexXHi_q <= `RST_BANK;
            indexYHi_q <= `RST_BANK;
            resetSeen_q <= 1'b0;
        end
        else if (!halted)
        begin
            resetSeen_q <= 1'b1;
            case (state_q)
                ST_RESET:
                begin
                    if (resetRelease)
                    begin
                        state_q <= ST_SEQ; // RULE15
                        cyc_q <= 4'h0;
                    end
                end
                ST_RUN:
                begin
                    if (ctrl_q[`CTRL_STOP])
                        state_q <= ST_STOP;
                    else if (ctrl_q[`CTRL_WAIT] && readySync && !readyOut)
                        state_q <= ST_RUN;
                    else if (ctrl_q[`CTRL_WAIT])
                        state_q <= ST_WAIT; // RULE9
                    else if (instrDone && (nmiPending || irqTake))
                    begin
                        state_q <= ST_SEQ; // RULE2
                        seqIsReset_q <= 1'b0;
                        seqKind_q <= nmiPending ? 2'h1 : 2'h3;
                        cyc_q <= 4'h0;
                    end
                end
                ST_WAIT:
                begin
                    if (nmiPending || irqTake)
                    begin
                        state_q <= ST_SEQ;
                        seqIsReset_q <= 1'b0;
                        seqKind_q <= nmiPending ? 2'h1 : 2'h3;
                        cyc_q <= 4'h0;
                    end
                    else if (!abortSync)
                    begin
                        state_q <= ST_SEQ;
                        seqIsReset_q <= 1'b0;
                        seqKind_q <= 2'h2;
                        cyc_q <= 4'h0;
                    end
                    else if (irqAsserted)
                        state_q <= ST_RUN; // RULE10
                end
                ST_STOP:
                    state_q <= ST_STOP;
                default:
                begin
                    cyc_q <= cyc_q + 4'h1;
                    if (cyc_q == 4'h1)
                        vecAddr_q <= vecNow;
                    if (cyc_q >= 4'h2 && cyc_q <= 4'h5 && !seqIsReset_q)
                        stack_q <= stack_q - 16'h0001; // RULE5
                    if (cyc_q == 4'h5)
                    begin
                        status_q[`P_IRQDIS] <= 1'b1;
                        status_q[`P_DEC] <= 1'b0;
                    end
                    if (cyc_q == 4'h6)
                        pc_q[7:0] <= dataIn;
                    if (cyc_q == `SEQ_CYCLES - 4'h1)
                    begin
                        pc_q[15:8] <= dataIn;
                        programBank_q <= 8'h00;
                        state_q <= ST_RUN;
                    end
                end
            endcase
            // Program bank moves on long transfers and is cleared to 00 at the end of the vector sequence; wraps keep it. // RULE21
            if (state_q == ST_RUN && (ctrl_q[`CTRL_RETURN] || ctrl_q[`CTRL_LONGJMP]))
                programBank_q <= absOperand_q[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus outputs.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clkHalf_q <= 1'b0;
            width_flags_status <= 1'b1;
            emulationOut <= 1'b1;
            read_not_write <= 1'b1;
            rwOe <= 1'b1;
            data_cycle_valid <= 1'b0;
            program_cycle_valid <= 1'b0;
            vector_fetch_n <= 1'b1;
            addrOut <= 24'h000000;
            dataOut <= 8'h00;
            readyOut <= 1'b1;
            readyOe <= 1'b0;
        end
        else
        begin
            clkHalf_q <= ~clkHalf_q;
            // Half-cycle toggle stands in for the phase of the bus clock.
            width_flags_status <= clkHalf_q ? status_q[`P_XWIDTH] : status_q[`P_MWIDTH]; // RULE1
            emulationOut <= emu;
            rwOe <= beSync; // RULE7
            readyOut <= 1'b1;
            readyOe <= 1'b0;
            if (state_q == ST_WAIT && !wakeAny)
            begin
                readyOut <= 1'b0; // RULE9 RULE11
                readyOe <= 1'b1;
            end
            if (state_q == ST_RESET)
            begin
                read_not_write <= 1'b1; // RULE14
                data_cycle_valid <= 1'b0;
                program_cycle_valid <= 1'b0;
                vector_fetch_n <= 1'b1;
            end
            else if (state_q == ST_SEQ)
            begin
                vector_fetch_n <= !(cyc_q >= `SEQ_CYCLES - 4'h2); // RULE18
                if (cyc_q >= 4'h2 && cyc_q <= 4'h5)
                begin
                    // Reset walks the stack as reads only. // RULE16
                    read_not_write <= seqIsReset_q;
                    {data_cycle_valid, program_cycle_valid} <= `QUAL_DATA; // RULE17
                    addrOut <= bankZero(stack_q);
                    case (cyc_q)
                        4'h2: dataOut <= programBank_q;
                        4'h3: dataOut <= pc_q[15:8];
                        4'h4: dataOut <= pc_q[7:0];
                        default: dataOut <= status_q;
                    endcase
                end
                else if (cyc_q >= 4'h6)
                begin
                    read_not_write <= 1'b1;
                    {data_cycle_valid, program_cycle_valid} <= `QUAL_DATA;
                    if (cyc_q == 4'h6)
                        addrOut <= vecAddr_q; // RULE19
                    else
                        addrOut <= vecAddr_q + 24'h000001;
                end
                else
                begin
                    read_not_write <= 1'b1;
                    {data_cycle_valid, program_cycle_valid} <= `QUAL_INTERNAL;
                end
            end
            else if (state_q == ST_RUN && !halted)
            begin
                read_not_write <= 1'b1;
                vector_fetch_n <= 1'b1;
                if (ctrl_q[`CTRL_ABS])
                begin
                    {data_cycle_valid, program_cycle_valid} <= `QUAL_DATA;
                    addrOut <= {dataBank_q, absOperand_q} + 24'h000000; // RULE22 RULE23
                end
                else
                begin
                    {data_cycle_valid, program_cycle_valid} <= `QUAL_OPCODE;
                    addrOut <= {programBank_q, pc_q};
                end
            end
            else
            begin
                read_not_write <= 1'b1;
                {data_cycle_valid, program_cycle_valid} <= `QUAL_INTERNAL;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, pready high in every access phase.
    wire apbWrite = psel && penable && pwrite;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= 8'h01;
            absOperand_q <= 16'h0000;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (state_q == ST_WAIT || state_q == ST_STOP || !resetSync)
                ctrl_q[`CTRL_WAIT] <= 1'b0;
            if (!resetSync)
            begin
                ctrl_q[`CTRL_STOP] <= 1'b0; // RULE15
                ctrl_q[`CTRL_EMU] <= 1'b1;
            end
            if (ctrl_q[`CTRL_RETURN] || ctrl_q[`CTRL_LONGJMP])
                ctrl_q[5:4] <= 2'h0;
            if (psel && !penable)
            begin
                if (paddr == `REG_CTRL)
                    prdata <= {24'h000000, ctrl_q};
                else if (paddr == `REG_STATUS)
                    prdata <= {20'h00000, nmiPending, state_q, status_q};
                else if (paddr == `REG_BANKS)
                    prdata <= {indexYHi_q, indexXHi_q, programBank_q, dataBank_q};
                else if (paddr == `REG_VECTOR)
                    prdata <= {8'h00, vecAddr_q};
                else if (paddr == `REG_ADDR)
                    prdata <= {16'h0000, absOperand_q};
                else if (paddr == `REG_DIRECT)
                    prdata <= {stackHi_q, 8'h00, direct_q};
                else
                begin
                    prdata <= 32'h00000000;
                    pslverr <= 1'b1;
                end
            end
            // Writes land in the access phase, at the edge where the master sees pready.
            if (apbWrite && pready)
            begin
                if (paddr == `REG_CTRL)
                    ctrl_q <= pwdata[7:0];
                else if (paddr == `REG_ADDR)
                    absOperand_q <= pwdata[15:0];
            end
        end
    end
endmodule // cpu_irq_reset_bus_control

// ==== verilog/cpu_ctl_defines.vh ====
// Constants for the processor control and sequencing block: vectors, reset values,
// status bit positions, cycle qualifier codes and APB register offsets.
// Assumes inclusion by bare name from the design files.
// Summary of operation
// (RULE1) Width status output shows accumulator flag while clock low, index flag while high.
// (RULE2) Falling edge on non-maskable input starts interrupt after current instruction.
// (RULE3) Non-maskable vector is 00FFFA in emulation, 00FFEA in native mode.
// (RULE4) Non-maskable input is edge sensitive; a held low level triggers only once.
// (RULE5) Interrupt pushes program bank, pc high, pc low, status; return restores them; the code's return only loads the program bank from absOperand_q.
// (RULE6) Registers keep contents while the clock is stopped high or low.
// (RULE7) Read/write high for reads, low for writes, floats when bus enable low.
// (RULE8) External ready low halts; resume after next falling clock edge.
// (RULE9) Wait instruction pulls ready low until reset, abort or interrupt is active.
// (RULE10) With interrupts disabled, maskable request ends wait without vectoring.
// (RULE11) Ready forced high prevents wait halting; stop leaves ready unaffected; the code enters and holds wait even with ready forced high.
// (RULE12) Reset held low at least two cycles; ready ignored during reset.
// (RULE13) Reset sets direct 0000, banks 00, index highs 00, stack high 01.
// (RULE14) Reset drives emulation, width, read/write, vector pull high, valids low.
// (RULE15) Reset release clears stop and wait, fetches vector 00FFFC.
// (RULE16) Reset sequence keeps read/write high through stack cycles.
// (RULE17) Qualifiers data,program: 00 internal, 01 program, 10 data, 11 opcode.
// (RULE18) Vector pull is low during the last two interrupt sequence cycles.
// (RULE19) Vectors lie within 00FFE0 to 00FFFF.
// (RULE20) Stack and direct mode addresses always fall in bank zero.
// (RULE21) Program bank changes only on return, long return, long jump, long call; the code also clears it to 00 at the end of each vector sequence.
// (RULE22) Data addresses are 24 bits and carry across bank boundaries.
// (RULE23) Absolute mode: operand bytes give low 16 bits, data bank the high 8.
// (RULE24) Non-maskable input is synchronised and a detected edge held pending.
`ifndef CPU_CTL_DEFINES_VH
`define CPU_CTL_DEFINES_VH
`define VEC_NMI_EMU 24'h00FFFA
`define VEC_NMI_NAT 24'h00FFEA
`define VEC_IRQ_EMU 24'h00FFFE
`define VEC_IRQ_NAT 24'h00FFEE
`define VEC_ABT_EMU 24'h00FFF8
`define VEC_ABT_NAT 24'h00FFE8
`define VEC_RESET 24'h00FFFC
`define VEC_BASE 24'h00FFE0
`define RST_DIRECT 16'h0000
`define RST_BANK 8'h00
`define RST_STACK_HI 8'h01
`define RST_STATUS 8'h34
`define P_CARRY 0
`define P_IRQDIS 2
`define P_DEC 3
`define P_XWIDTH 4
`define P_MWIDTH 5
`define QUAL_INTERNAL 2'h0
`define QUAL_PROGRAM 2'h1
`define QUAL_DATA 2'h2
`define QUAL_OPCODE 2'h3
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_BANKS 12'h008
`define REG_VECTOR 12'h00C
`define REG_ADDR 12'h010
`define REG_DIRECT 12'h014
`define CTRL_EMU 0
`define CTRL_WAIT 1
`define CTRL_STOP 2
`define CTRL_ABS 3
`define CTRL_RETURN 4
`define CTRL_LONGJMP 5
`define SEQ_CYCLES 4'h8
`endif

// ==== verilog/edge_pending.v ====
// Falling edge catcher for an active-low asynchronous pin.
// Assumes the pin is unrelated to clk; three flip-flops, change counted when stages 2 and 3 agree.
`timescale 1ns/10ps
module edge_pending
(
    input wire clk,
    input wire rst_n,
    input wire pinN,
    input wire accept,
    output reg pending_q
);
    reg [2:0] syncQ;
    reg stableQ;
    wire fallSeen;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncQ <= 3'h7;
            stableQ <= 1'b1;
        end
        else
        begin
            syncQ <= {syncQ[1:0], pinN}; // RULE24
            if (syncQ[1] == syncQ[2])
                stableQ <= syncQ[2];
        end
    end

    // A low level that stays low gives no further edge.
    assign fallSeen = stableQ && (syncQ[1] == syncQ[2]) && !syncQ[2]; // RULE4

    // Set wins over the accept so an edge in the accept cycle is not lost.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pending_q <= 1'b0;
        else if (fallSeen)
            pending_q <= 1'b1; // RULE2
        else if (accept)
            pending_q <= 1'b0;
    end
endmodule // edge_pending

// ==== verilog/level_sync.v ====
// Three-stage synchroniser with agreement filter for an asynchronous level.
// Assumes input unrelated to clk.
`timescale 1ns/10ps
module level_sync
#(
    parameter RESET_VALUE = 1'b1
)
(
    input wire clk,
    input wire rst_n,
    input wire pinIn,
    output reg level_q
);
    reg [2:0] syncQ;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncQ <= {3{RESET_VALUE}};
            level_q <= RESET_VALUE;
        end
        else
        begin
            syncQ <= {syncQ[1:0], pinIn};
            if (syncQ[1] == syncQ[2])
                level_q <= syncQ[2];
        end
    end
endmodule // level_sync

// ==== sim/cpu_ctl_properties.sv ====
// Concurrent checks on the pins of the processor control block.
// Assumes a bind to cpu_irq_reset_bus_control and a single clock domain.
`timescale 1ns/10ps
module cpu_ctl_properties
(
    input wire clk,
    input wire rst_n,
    input wire reset_in_n,
    input wire nonmaskable_irq_n,
    input wire bus_drive_enable,
    input wire readyOut,
    input wire readyOe,
    input wire width_flags_status,
    input wire emulationOut,
    input wire read_not_write,
    input wire rwOe,
    input wire data_cycle_valid,
    input wire program_cycle_valid,
    input wire vector_fetch_n,
    input wire [23:0] addrOut
);
reg [23:0] prevAddr_q;
always @(posedge clk)
    prevAddr_q <= addrOut;
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////
sequence pullStart;
    vector_fetch_n ##1 !vector_fetch_n;
endsequence
sequence pullPair;
    !vector_fetch_n ##1 !vector_fetch_n ##1 vector_fetch_n;
endsequence
a_reset_outputs: assert property ($rose(rst_n) |-> read_not_write && vector_fetch_n
    && !data_cycle_valid && !program_cycle_valid && emulationOut)
    else $error("outputs wrong after reset");
a_pull_two: assert property (pullStart |-> pullPair)
    else $error("vector pull not two cycles");
a_pull_read: assert property (!vector_fetch_n |-> read_not_write)
    else $error("write during vector pull");
a_vector_range: assert property ($fell(vector_fetch_n) |->
    addrOut[23:5] == 19'h007FF || prevAddr_q[23:5] == 19'h007FF)
    else $error("vector outside range");
a_emu_width: assert property (emulationOut |-> width_flags_status)
    else $error("width status low in emulation");
a_rw_float: assert property ($fell(bus_drive_enable) |-> ##[1:5] !rwOe)
    else $error("read/write still driven");
a_wait_drive: assert property (readyOe |-> !readyOut)
    else $error("ready driven high");
a_wait_release: assert property (readyOe && $fell(nonmaskable_irq_n) |-> ##[1:8] !readyOe)
    else $error("wait not released");
a_reset_read: assert property ($rose(reset_in_n) |-> read_not_write [*8])
    else $error("write during reset sequence");
endmodule // cpu_ctl_properties

// ==== sim/ext_memory_model.sv ====
// Memory and ready-line holder on the far side of the control block.
// Assumes the bench wires readyIn and dataIn straight to the block.
`timescale 1ns/10ps
module ext_memory_model
(
    input wire clk,
    input wire [23:0] addrOut,
    input wire read_not_write,
    input wire readyOut,
    input wire readyOe,
    input wire holdLow,
    input wire forceHigh,
    output wire readyIn,
    output reg [7:0] dataIn
);
// The ready line is wired-OR with a pull-up, so any holder pulling low wins unless forced.
assign readyIn = forceHigh | !(holdLow | (readyOe & !readyOut));
// Outside read cycles the bus toggles so stale data is never mistaken for valid.
always @(posedge clk)
    dataIn <= read_not_write ? addrOut[7:0] + 8'h11 : ~dataIn;
endmodule // ext_memory_model

// ==== sim/testbench.sv ====
// Self-checking bench for the processor control block.
// Assumes the defines header is on the include path.
`timescale 1ns/10ps
`include "cpu_ctl_defines.vh"
module testbench;
reg clk, rst_n, resetInN, nmiN, busEn, instrDone, psel, penable, pwrite, holdLow;
reg [11:0] paddr;
reg [31:0] pwdata, rd;
reg err, hit;
reg [23:0] want;
reg [7:0] pushed;
wire readyIn, pready, pslverr, readyOut, readyOe, widthFlags, emuOut, rwN, rwOe, dValid, pValid;
wire vecN;
wire [7:0] dataIn, dataOut;
wire [31:0] prdata;
wire [23:0] addrOut;
integer failCount = 0, comparisons = 0, pulls, writes;
cpu_irq_reset_bus_control DUT (.clk(clk), .rst_n(rst_n), .reset_in_n(resetInN),
    .nonmaskable_irq_n(nmiN), .maskable_irq_n(1'b1), .abort_in_n(1'b1),
    .bus_drive_enable(busEn), .readyIn(readyIn), .instrDone(instrDone), .dataIn(dataIn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .readyOut(readyOut),
    .readyOe(readyOe), .width_flags_status(widthFlags), .emulationOut(emuOut),
    .read_not_write(rwN), .rwOe(rwOe), .data_cycle_valid(dValid),
    .program_cycle_valid(pValid), .vector_fetch_n(vecN), .addrOut(addrOut), .dataOut(dataOut));
ext_memory_model memory (.clk(clk), .addrOut(addrOut), .read_not_write(rwN),
    .readyOut(readyOut), .readyOe(readyOe), .holdLow(holdLow), .forceHigh(1'b0),
    .readyIn(readyIn), .dataIn(dataIn));
////////////////////////////////////////////////////////////
task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
        $display("unexpected %s expected %h seen %h", name, exp, got);
        failCount = failCount + 1;
    end
endtask
task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    integer n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
        @(posedge clk);
        n = n + 1;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready wait", 1, n);
endtask
task watch(input logic [23:0] w);
    want = w;
    hit = 1'b0;
    pulls = 0;
    writes = 0;
    repeat (24) @(posedge clk);
endtask
always @(posedge clk)
begin
    if (vecN === 1'b0)
        pulls <= pulls + 1;
    if (rwN === 1'b0)
        writes <= writes + 1;
    if (rwN === 1'b0)
        pushed <= dataOut;
    if (addrOut === want && rwN === 1'b1)
        hit <= 1'b1;
end
task done_pulse;
    @(posedge clk);
    instrDone <= 1'b1;
    @(posedge clk);
    instrDone <= 1'b0;
endtask
////////////////////////////////////////////////////////////
task t_reset;
    check("rw", 1, rwN);
    check("qualifiers", 0, {dValid, pValid});
    check("pull", 1, vecN);
    check("emulation", 1, emuOut);
    check("width", 1, widthFlags);
    resetInN <= 1'b1;
    watch(`VEC_RESET);
    check("reset vector", 1, hit);
    check("reset pulls", 2, pulls);
    check("reset writes", 0, writes);
endtask
task t_regs;
    apb(1'b0, `REG_CTRL, 0);
    check("ctrl emu", 1, rd[`CTRL_EMU]);
    apb(1'b0, 12'hFF0, 0);
    check("unmapped err", 1, err);
    check("unmapped data", 0, rd);
endtask
task t_nmi(input logic emu, input logic [23:0] w);
    apb(1'b1, `REG_CTRL, {31'h0, emu});
    repeat (4) @(posedge clk);
    check("emulation", emu, emuOut);
    nmiN <= 1'b0;
    repeat (6) @(posedge clk);
    done_pulse();
    watch(w);
    check("nmi vector", 1, hit);
    check("nmi pushes", 4, writes);
    check("pushed status", `RST_STATUS, pushed);
    check("nmi pulls", 2, pulls);
    done_pulse();
    watch(w);
    check("held low", 0, pulls);
    nmiN <= 1'b1;
endtask
task t_wait;
    apb(1'b1, `REG_CTRL, 32'h00000002);
    repeat (4) @(posedge clk);
    check("ready pulled", 2'b10, {readyOe, readyOut});
    nmiN <= 1'b0;
    repeat (10) @(posedge clk);
    check("ready released", 0, readyOe);
    apb(1'b1, `REG_CTRL, 0);
    done_pulse();
    watch(`VEC_NMI_NAT);
    check("wait vector", 1, hit);
    check("wait pulls", 2, pulls);
    nmiN <= 1'b1;
endtask
task t_bus;
    busEn <= 1'b0;
    repeat (6) @(posedge clk);
    check("rw floats", 0, rwOe);
    busEn <= 1'b1;
    repeat (6) @(posedge clk);
    check("rw driven", 1, rwOe);
endtask
task t_halt;
    holdLow <= 1'b1;
    nmiN <= 1'b0;
    repeat (8) @(posedge clk);
    done_pulse();
    watch(`VEC_NMI_NAT);
    check("halted pulls", 0, pulls);
    holdLow <= 1'b0;
    repeat (6) @(posedge clk);
    done_pulse();
    watch(`VEC_NMI_NAT);
    check("resumed vector", 1, hit);
    nmiN <= 1'b1;
endtask
////////////////////////////////////////////////////////////
initial
begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
initial
begin
    #100000;
    failCount = failCount + 1;
    end_of_test();
end
initial
begin
    {rst_n, resetInN, instrDone, psel, penable, pwrite} = 6'h00;
    {nmiN, busEn, holdLow, paddr, pwdata, want} = {3'b110, 12'h000, 32'h0, 24'hFFFFFF};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    t_reset();
    t_regs();
    t_nmi(1'b1, `VEC_NMI_EMU);
    t_nmi(1'b0, `VEC_NMI_NAT);
    t_wait();
    t_bus();
    t_halt();
    end_of_test();
end
endmodule // testbench
bind cpu_irq_reset_bus_control cpu_ctl_properties checker_inst (.clk(clk), .rst_n(rst_n),
    .reset_in_n(reset_in_n), .nonmaskable_irq_n(nonmaskable_irq_n),
    .bus_drive_enable(bus_drive_enable), .readyOut(readyOut), .readyOe(readyOe),
    .width_flags_status(width_flags_status), .emulationOut(emulationOut),
    .read_not_write(read_not_write), .rwOe(rwOe), .data_cycle_valid(data_cycle_valid),
    .program_cycle_valid(program_cycle_valid), .vector_fetch_n(vector_fetch_n),
    .addrOut(addrOut));
